/* File: fpd_defines.svh */
// Constants for the fan PWM duty generator: rates, codes and reset values.
// Assumes a 10 MHz system clock; included by the package and the design modules.
`ifndef FPD_DEFINES_SVH
`define FPD_DEFINES_SVH

// ****************************************************************
// Rates in Hz and derived accumulator increments
// ****************************************************************
`define FPD_CLK_HZ         24'h98_9680
`define FPD_BASE_FAST_HZ   24'h05_7E40
`define FPD_BASE_SLOW_HZ   24'h00_0578
`define FPD_HR_OUT_HZ      24'h00_57E4
`define FPD_HR_STEPS       8'hFF
`define FPD_HR_STEP_HZ     24'h57_8C1C

// ****************************************************************
// Codes, field widths and reset values
// ****************************************************************
`define FPD_FREQ_W         5
`define FPD_DUTY_W         8
`define FPD_NORM_DUTY_W    6
`define FPD_HR_FREQ_CODE   5'h08
`define FPD_FREQ_ZERO      5'h00
`define FPD_FREQ_ONE       5'h01
`define FPD_DUTY_FULL      8'hFF
`define FPD_HR_LAST_STEP   8'hFE
`define FPD_CNT_RST        8'h00
`define FPD_ACC_W          24

`endif

/* File: fpd_pkg.sv */
// Types shared by the fan PWM duty generator modules.
// Assumes fpd_defines.svh is on the include path.
`include "fpd_defines.svh"

package fpd_pkg;

  typedef enum logic [1:0]
  {
    FPD_NORMAL = 2'b01,
    FPD_HIRES  = 2'b10
  } fpd_mode_t;

  typedef logic [`FPD_FREQ_W-1:0] fpd_freq_t;
  typedef logic [`FPD_DUTY_W-1:0] fpd_duty_t;

endpackage

/* File: fpd_tick_if.sv */
// Carrier for one rate tick between a tick generator and the PWM core.
// Assumes both ends share one clock.
interface fpd_tick_if;
  logic tick;

  modport src
  (
    output tick
  );

  modport dst
  (
    input  tick
  );
endinterface

/* File: fpd_tick_gen.sv */
// Fractional rate tick generator: one-cycle tick at RATE_HZ on average.
// Assumes clk runs at CLK_HZ; a phase accumulator spreads the remainder.
`include "fpd_defines.svh"

module fpd_tick_gen
#(
  parameter logic [`FPD_ACC_W-1:0] CLK_HZ  = `FPD_CLK_HZ,
  parameter logic [`FPD_ACC_W-1:0] RATE_HZ = `FPD_BASE_FAST_HZ
)
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Tick out
  fpd_tick_if.src     tk
);
  import fpd_pkg::*;

  logic [`FPD_ACC_W:0]   sum;
  logic                  wrap;
  logic [`FPD_ACC_W-1:0] acc_r;
  logic [`FPD_ACC_W-1:0] acc_nxt;
  logic                  tick_r;

  assign sum     = {1'b0, acc_r} + {1'b0, RATE_HZ};
  assign wrap    = (sum >= {1'b0, CLK_HZ});
  assign acc_nxt = wrap ? sum[`FPD_ACC_W-1:0] - CLK_HZ : sum[`FPD_ACC_W-1:0];
  assign tk.tick = tick_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      acc_r  <= acc_nxt;
      tick_r <= wrap;
    end
  end
endmodule

/* File: fpd_pwm_gen.sv */
// Fan drive PWM generator with normal and 22.5 kHz high-resolution modes.
// Assumes configuration inputs come from logic on clk; fan pin is open drain.
`include "fpd_defines.svh"

module fpd_pwm_gen
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Configuration
  input  wire logic              high_res_duty_enable,
  input  wire logic              pwm_base_clock_select,
  input  wire fpd_pkg::fpd_freq_t freq_setting,
  input  wire fpd_pkg::fpd_duty_t duty_value,
  // Status
  output logic                   hires_active,
  output logic                   pwm_active,
  // Open-drain fan drive pin
  output logic                   fan_pwm_pin,
  output logic                   fan_pwm_oe
);
  import fpd_pkg::*;

  // ****************************************************************
  // Rate ticks
  // ****************************************************************
  fpd_tick_if fast_tk ();
  fpd_tick_if slow_tk ();
  fpd_tick_if step_tk ();

  fpd_tick_gen
  #(
    .CLK_HZ  (`FPD_CLK_HZ),
    .RATE_HZ (`FPD_BASE_FAST_HZ)
  )
  u_fast
  (
    .clk  (clk),
    .nrst (nrst),
    .tk   (fast_tk)
  );

  fpd_tick_gen
  #(
    .CLK_HZ  (`FPD_CLK_HZ),
    .RATE_HZ (`FPD_BASE_SLOW_HZ)
  )
  u_slow
  (
    .clk  (clk),
    .nrst (nrst),
    .tk   (slow_tk)
  );

  // Fine step: 255 steps per 22.5 kHz period, spread over the system clock
  fpd_tick_gen
  #(
    .CLK_HZ  (`FPD_CLK_HZ),
    .RATE_HZ (`FPD_HR_STEP_HZ)
  )
  u_step
  (
    .clk  (clk),
    .nrst (nrst),
    .tk   (step_tk)
  );

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  fpd_mode_t               mode_r;
  fpd_mode_t               mode_nxt;
  logic                    hr_req;
  logic                    hr_base_ok;
  logic                    hr_code_ok;
  logic                    hr_sel;
  logic                    mode_chg;
  fpd_freq_t               freq_eff;
  logic [`FPD_DUTY_W-1:0]  period_last;
  logic                    base_tick;
  logic                    step_en;
  logic                    at_last;

  // Enable, fast base clock and code eight all needed
  assign hr_req     = high_res_duty_enable;
  assign hr_base_ok = ~pwm_base_clock_select;
  assign hr_code_ok = (freq_setting == `FPD_HR_FREQ_CODE);
  assign hr_sel     = hr_req & hr_base_ok & hr_code_ok;
  assign mode_nxt   = hr_sel ? FPD_HIRES : FPD_NORMAL;
  assign mode_chg   = (mode_nxt != mode_r);

  assign freq_eff    = (freq_setting == `FPD_FREQ_ZERO) ? `FPD_FREQ_ONE
                                                         : freq_setting;
  // Last count of a 2N-tick period
  assign period_last = {2'b00, freq_eff, 1'b0} - 8'h01;
  assign base_tick   = pwm_base_clock_select ? slow_tk.tick : fast_tk.tick;

  // ****************************************************************
  // Period counter
  // ****************************************************************
  logic [`FPD_DUTY_W-1:0]  cnt_r;
  logic [`FPD_DUTY_W-1:0]  cnt_nxt;
  logic [`FPD_DUTY_W-1:0]  cnt_inc;
  logic                    cnt_wrap;
  logic                    active_nxt;
  logic                    pwm_active_r;
  logic                    pin_oe_r;
  logic                    hires_r;
  logic                    hires_nxt;
  logic                    hr_full;
  logic                    hr_below;
  logic                    norm_below;
  logic [`FPD_DUTY_W-1:0]  norm_duty;

  always_comb
  begin
    step_en = 1'b0;
    at_last = 1'b0;
    case (mode_r)
      FPD_HIRES:
      begin
        step_en = step_tk.tick;
        at_last = (cnt_r >= `FPD_HR_LAST_STEP);
      end
      FPD_NORMAL:
      begin
        step_en = base_tick;
        at_last = (cnt_r >= period_last);
      end
      default:
      begin
        step_en = 1'b0;
        at_last = 1'b1;
      end
    endcase
  end

  assign cnt_inc  = cnt_r + 8'h01;
  assign cnt_wrap = step_en & at_last;
  assign cnt_nxt  = mode_chg  ? `FPD_CNT_RST
                  : !step_en  ? cnt_r
                  : cnt_wrap  ? `FPD_CNT_RST
                  : cnt_inc;

  // ****************************************************************
  // Duty compare
  // ****************************************************************
  assign norm_duty  = {2'b00, duty_value[`FPD_NORM_DUTY_W-1:0]};
  assign hr_full    = (duty_value == `FPD_DUTY_FULL);
  assign hr_below   = (cnt_nxt < duty_value);
  assign norm_below = (cnt_nxt < norm_duty);
  assign hires_nxt  = (mode_nxt == FPD_HIRES);
  // Compare in the mode taking effect, so a mode change starts clean
  assign active_nxt = hires_nxt ? (hr_full | hr_below) : norm_below;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_r <= FPD_NORMAL;
      cnt_r  <= `FPD_CNT_RST;
    end
    else
    begin
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_active_r <= 1'b0;
    end
    else
    begin
      pwm_active_r <= active_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_oe_r <= 1'b1;
    end
    else
    begin
      pin_oe_r <= ~active_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hires_r <= 1'b0;
    end
    else
    begin
      hires_r <= hires_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Active phase releases the pin; inactive phase pulls it low
  assign fan_pwm_pin  = 1'b0;
  assign fan_pwm_oe   = pin_oe_r;
  assign pwm_active   = pwm_active_r;
  assign hires_active = hires_r;
endmodule

/* File: fpd_pwm_asserts.sv */
// Port assertions for the fan PWM generator.
// Bound into every fpd_pwm_gen instance; fpd_pkg is compiled first.
module fpd_pwm_asserts
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Configuration
  input wire logic               high_res_duty_enable,
  input wire logic               pwm_base_clock_select,
  input wire fpd_pkg::fpd_freq_t freq_setting,
  input wire fpd_pkg::fpd_duty_t duty_value,
  // Outputs
  input wire logic               hires_active,
  input wire logic               pwm_active,
  input wire logic               fan_pwm_pin,
  input wire logic               fan_pwm_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hr;
  assign hr = high_res_duty_enable && !pwm_base_clock_select && freq_setting == 5'h08;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_hires_enter: assert property (hr |=> hires_active)
    else $error("hires not entered");
  a_hires_refuse: assert property (!hr |=> !hires_active)
    else $error("hires without full setting");
  a_slow_base: assert property (pwm_base_clock_select |=> !hires_active)
    else $error("hires on slow base");
  a_hr_full: assert property (hr && hires_active && duty_value == 8'hFF |=> pwm_active)
    else $error("full duty not active");
  a_hr_zero: assert property (hr && hires_active && duty_value == 8'h00 |=> !pwm_active)
    else $error("zero duty active");
  a_norm_zero: assert property (!hr && duty_value[5:0] == 6'h00 |=> !pwm_active)
    else $error("normal zero duty active");
  a_norm_full: assert property (!hr && duty_value[5:0] == 6'h3F |=> pwm_active)
    else $error("normal full duty idle");
  a_pin_drive: assert property (fan_pwm_oe == !pwm_active && !fan_pwm_pin)
    else $error("pin drive wrong");
  c_hires: cover property (hires_active && duty_value == 8'hBF);
  c_code_zero: cover property (freq_setting == 5'h00 && $rose(pwm_active));
  c_slow: cover property (pwm_base_clock_select && high_res_duty_enable);
endmodule

bind fpd_pwm_gen fpd_pwm_asserts u_fpd_pwm_asserts
(
  .clk(clk), .nrst(nrst), .high_res_duty_enable(high_res_duty_enable),
  .pwm_base_clock_select(pwm_base_clock_select), .freq_setting(freq_setting),
  .duty_value(duty_value), .hires_active(hires_active), .pwm_active(pwm_active),
  .fan_pwm_pin(fan_pwm_pin), .fan_pwm_oe(fan_pwm_oe)
);

/* File: fpd_fan_model.sv */
// Fan PWM input: pulled-up open-drain pin, counts high samples and rises.
// Assumes the pin is sampled on the system clock.
module fpd_fan_model
(
  // Clock and pin
  input wire logic clk,
  input wire logic fan_pwm_pin,
  input wire logic fan_pwm_oe,
  // Running counts
  output int       high_cnt,
  output int       rise_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin;
  logic pin_q = 1'b1;
  int   high_q = 0;
  int   rise_q = 0;
  // Pull-up sets the level while the pin is released
  assign pin = fan_pwm_oe ? fan_pwm_pin : 1'b1;
  assign high_cnt = high_q;
  assign rise_cnt = rise_q;
  always @(posedge clk)
  begin
    high_q <= high_q + int'(pin);
    rise_q <= rise_q + int'(pin && !pin_q);
    pin_q <= pin;
  end
endmodule

/* File: test_fpd_pwm_gen.sv */
// Self-checking bench for the fan PWM generator.
// Assumes design, checker and fan model are compiled first.
module test_fpd_pwm_gen;
  timeunit 1ns;
  timeprecision 1ns;
  import fpd_pkg::*;
  logic      clk = 1'b0;
  logic      nrst = 1'b0;
  logic      high_res_duty_enable = 1'b0;
  logic      pwm_base_clock_select = 1'b0;
  fpd_freq_t freq_setting = 5'h01;
  fpd_duty_t duty_value = 8'h00;
  logic      hires_active, pwm_active, fan_pwm_pin, fan_pwm_oe;
  int        high_cnt, rise_cnt, h, r;
  int        failures = 0;
  int        total_checks = 0;
  always #50 clk = ~clk;
  fpd_pwm_gen u_fpd_pwm_gen (.clk(clk), .nrst(nrst),
    .high_res_duty_enable(high_res_duty_enable), .pwm_base_clock_select(pwm_base_clock_select),
    .freq_setting(freq_setting), .duty_value(duty_value), .hires_active(hires_active),
    .pwm_active(pwm_active), .fan_pwm_pin(fan_pwm_pin), .fan_pwm_oe(fan_pwm_oe));
  fpd_fan_model u_fpd_fan_model (.clk(clk), .fan_pwm_pin(fan_pwm_pin), .fan_pwm_oe(fan_pwm_oe),
    .high_cnt(high_cnt), .rise_cnt(rise_cnt));
  task automatic chk_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_rng(int got, int lo, int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("MISMATCH %0t count %0d want %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Apply a setting, then let 600 clock cycles pass
  task automatic cfg(logic en, logic sel, fpd_freq_t f, fpd_duty_t d);
    @(posedge clk);
    high_res_duty_enable <= en;
    pwm_base_clock_select <= sel;
    freq_setting <= f;
    duty_value <= d;
    repeat (600) @(posedge clk);
  endtask
  task automatic meas(int w);
    int h0, r0;
    h0 = high_cnt;
    r0 = rise_cnt;
    repeat (w) @(posedge clk);
    h = high_cnt - h0;
    r = rise_cnt - r0;
  endtask
  task automatic t_norm;
    for (int i = 0; i < 2; i++)
    begin
      cfg(1'b0, 1'b0, 5'(1 - i), 8'h01);
      meas(2000);
      chk_rng(r, 35, 37);
      chk_rng(h, 950, 1050);
    end
    cfg(1'b0, 1'b0, 5'h01, 8'hC0);
    meas(200);
    chk_rng(h, 0, 0);
    cfg(1'b0, 1'b0, 5'h1F, 8'h3F);
    meas(200);
    chk_rng(h, 200, 200);
    // Slow base: N=1 gives a period of two 1.4 kHz ticks
    cfg(1'b0, 1'b1, 5'h01, 8'h01);
    meas(15000);
    chk_rng(r, 1, 2);
    chk_rng(h, 7000, 8000);
  endtask
  task automatic t_hires;
    cfg(1'b1, 1'b0, 5'h08, 8'hBF);
    chk_bit(hires_active, 1'b1);
    meas(20000);
    chk_rng(r, 44, 46);
    chk_rng(h, 14530, 15430);
    cfg(1'b1, 1'b0, 5'h08, 8'h80);
    meas(20000);
    chk_rng(h, 9589, 10489);
    cfg(1'b1, 1'b0, 5'h08, 8'hFF);
    meas(4000);
    chk_rng(h, 4000, 4000);
    chk_bit(pwm_active, 1'b1);
    chk_bit(fan_pwm_oe, 1'b0);
    cfg(1'b1, 1'b0, 5'h08, 8'h00);
    meas(1000);
    chk_rng(h, 0, 0);
    chk_bit(pwm_active, 1'b0);
    chk_bit(fan_pwm_oe, 1'b1);
    chk_bit(fan_pwm_pin, 1'b0);
  endtask
  task automatic t_refuse;
    cfg(1'b1, 1'b1, 5'h08, 8'hBF);
    chk_bit(hires_active, 1'b0);
    cfg(1'b1, 1'b0, 5'h07, 8'hBF);
    chk_bit(hires_active, 1'b0);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_norm();
    t_hires();
    t_refuse();
    stop_test();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
